// ### inc/stepgen_pkg.sv
// Constants shared by the velocity step generator and diagnostic block.
// Assumes a 32-bit APB master and a single 125 MHz clock domain.
package stepgen_pkg;
   // ****************************************************************
   // Register byte offsets.
   // ****************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_VELOCITY = 8'h04;
   localparam logic [7:0] OFF_STATE = 8'h08;
   localparam logic [7:0] OFF_POSITION = 8'h0c;
   localparam logic [7:0] OFF_INTERVAL = 8'h10;
   localparam logic [7:0] OFF_THRESHOLD = 8'h14;
   localparam logic [7:0] OFF_INT_STATUS = 8'h18;
   localparam logic [7:0] OFF_INT_MASK = 8'h1c;
   // ****************************************************************
   // Field layout and widths.
   // ****************************************************************
   localparam int VEL_W = 24;
   localparam int ACC_W = 24;
   localparam int POS_W = 10;
   localparam int IVL_W = 20;
   localparam int CTRL_EN = 0;
   localparam int CTRL_SEL_LO = 1;
   localparam int CTRL_SEL_HI = 2;
   localparam int FULL_RES = 256;
   localparam logic [POS_W-1:0] POS_ZERO = 10'h000;
   localparam logic [IVL_W-1:0] IVL_MAX = 20'hfffff;
   localparam logic [1:0] SHORT_RETRIES = 2'h3;
   // Interrupt and status bit positions.
   localparam int EV_HOT = 0;
   localparam int EV_OTPW = 1;
   localparam int EV_SHORT = 2;
   localparam int EV_OLA = 3;
   localparam int EV_OLB = 4;
   localparam int EV_W = 5;
   // Diagnostic pin function select.
   localparam logic [1:0] DIAG_ERROR = 2'h0;
   localparam logic [1:0] DIAG_INDEX = 2'h1;
   localparam logic [1:0] DIAG_STEP = 2'h2;
   // Driver stage states, one-hot.
   typedef enum logic [3:0] {
      DRV_OFF = 4'b0001,
      DRV_ON = 4'b0010,
      DRV_SHORT = 4'b0100,
      DRV_HOT = 4'b1000
   } drv_state_e;
endpackage : stepgen_pkg

// ### hw/stepgen_diag.sv
// Velocity step pulse generator with thermal, short and open-load diagnostics.
// Assumes synchronous sensor inputs and an APB master; one clock, async reset.
`timescale 1ns/10ps
module stepgen_diag import stepgen_pkg::*; #(
   parameter int USTEPS = 256
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sensor inputs from the analog front end.
   input wire logic temp_prewarn_in,
   input wire logic temp_shutdown_in,
   input wire logic short_gnd_a_in,
   input wire logic short_gnd_b_in,
   input wire logic short_vs_a_in,
   input wire logic short_vs_b_in,
   input wire logic open_load_a_in,
   input wire logic open_load_b_in,
   // External step input.
   input wire logic ext_step_in,
   input wire logic ext_dir_in,
   // Outputs.
   output logic bridge_enable,
   output logic diag_pin,
   output logic irq
);
   // ****************************************************************
   // Elaboration checks and helpers.
   // ****************************************************************
   if (USTEPS < 1 || USTEPS > FULL_RES || (USTEPS & (USTEPS - 1)) != 0) begin : g_bad
      $error("USTEPS must be a power of two from 1 to 256");
   end

   // Position increment per executed step for a given resolution.
   function automatic logic [POS_W-1:0] step_width(input int res);
      step_width = POS_W'(FULL_RES / res);
   endfunction : step_width

   localparam logic [POS_W-1:0] STEP_W = step_width(USTEPS);

   // ****************************************************************
   // Registers and next values.
   // ****************************************************************
   logic ctrl_en_ff, nxt_ctrl_en;
   logic [1:0] diag_sel_ff, nxt_diag_sel;
   logic signed [VEL_W-1:0] vel_ff, nxt_vel;
   logic [IVL_W-1:0] thresh_ff, nxt_thresh;
   logic [EV_W-1:0] int_stat_ff, nxt_int_stat;
   logic [EV_W-1:0] int_mask_ff, nxt_int_mask;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic irq_ff, nxt_irq;
   logic [ACC_W-1:0] acc_ff, nxt_acc;
   logic [POS_W-1:0] pos_ff, nxt_pos;
   logic [IVL_W-1:0] cnt_ff, nxt_cnt, ivl_ff, nxt_ivl;
   logic ext_step_ff, nxt_ext_step;
   logic toggle_ff, nxt_toggle;
   drv_state_e state_ff, nxt_state;
   logic [1:0] retry_ff, nxt_retry;
   logic [3:0] short_ff, nxt_short;
   logic otpw_ff, nxt_otpw, ola_ff, nxt_ola, olb_ff, nxt_olb;
   logic bridge_ff, nxt_bridge, diag_ff, nxt_diag;
   logic step_evt, step_dir_down, carry, short_any, confirm;
   logic [VEL_W-1:0] vel_mag;
   logic [EV_W-1:0] events;
   logic access, wr, rd;

   assign access = psel && penable && pready_ff;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;

   // ****************************************************************
   // Step generator.
   // ****************************************************************
   // The accumulator adds the velocity magnitude every clock; its carry is a
   // microstep. A new velocity is used on the very next clock, no ramp.
   always_comb begin
      vel_mag = vel_ff[VEL_W-1] ? VEL_W'(-vel_ff) : VEL_W'(vel_ff);
      {carry, nxt_acc} = {1'b0, acc_ff} + {1'b0, vel_mag};
      nxt_ext_step = ext_step_in;
      if (vel_ff != '0) begin
         step_evt = carry;
         step_dir_down = vel_ff[VEL_W-1];
      end else begin
         step_evt = ext_step_in && !ext_step_ff;
         step_dir_down = ext_dir_in;
      end
      nxt_pos = step_evt ? (step_dir_down ? pos_ff - STEP_W : pos_ff + STEP_W) : pos_ff;
      nxt_toggle = step_evt ? !toggle_ff : toggle_ff;
      // The count saturates so the first step after a long stall reads as the slowest value.
      // The count restarts at one so it spans every clock between two steps.
      if (step_evt) begin
         nxt_cnt = IVL_W'(1'b1);
         nxt_ivl = IVL_W'(cnt_ff / IVL_W'(STEP_W));
      end else begin
         nxt_cnt = (cnt_ff == IVL_MAX) ? cnt_ff : cnt_ff + 1'b1;
         nxt_ivl = ivl_ff;
      end
   end

   // Step generator registers.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         acc_ff <= '0;
         pos_ff <= POS_ZERO;
         cnt_ff <= '0;
         ivl_ff <= IVL_MAX;
         ext_step_ff <= 1'b0;
         toggle_ff <= 1'b0;
      end else begin
         acc_ff <= nxt_acc;
         pos_ff <= nxt_pos;
         cnt_ff <= nxt_cnt;
         ivl_ff <= nxt_ivl;
         ext_step_ff <= nxt_ext_step;
         toggle_ff <= nxt_toggle;
      end
   end

   // ****************************************************************
   // Protection state machine.
   // ****************************************************************
   // A short must be seen on four detections (first plus three retries)
   // before the bridges drop, so a single ESD spike cannot stop the motor.
   always_comb begin
      short_any = short_gnd_a_in | short_gnd_b_in | short_vs_a_in | short_vs_b_in;
      confirm = (state_ff == DRV_ON) && short_any && (retry_ff == SHORT_RETRIES);
      nxt_retry = retry_ff;
      nxt_short = short_ff;
      nxt_otpw = temp_prewarn_in;
      nxt_ola = open_load_a_in;
      nxt_olb = open_load_b_in;
      nxt_state = state_ff;
      case (state_ff)
         DRV_OFF: begin
            nxt_retry = '0;
            if (ctrl_en_ff && !temp_shutdown_in) nxt_state = DRV_ON;
         end
         DRV_ON: begin
            if (!ctrl_en_ff) begin
               nxt_state = DRV_OFF;
            end else if (temp_shutdown_in) begin
               nxt_state = DRV_HOT;
            end else if (confirm) begin
               nxt_state = DRV_SHORT;
               nxt_short = {short_vs_b_in, short_vs_a_in, short_gnd_b_in, short_gnd_a_in};
            end else if (short_any) begin
               nxt_retry = retry_ff + 1'b1;
            end
         end
         DRV_SHORT: begin
            // Only a disable clears the short; enable alone keeps it off.
            if (!ctrl_en_ff) begin
               nxt_state = DRV_OFF;
               nxt_short = '0;
               nxt_retry = '0;
            end
         end
         DRV_HOT: begin
            if (!temp_prewarn_in && !temp_shutdown_in) nxt_state = DRV_OFF;
         end
         default: nxt_state = DRV_OFF;
      endcase
      nxt_bridge = (nxt_state == DRV_ON);
      case (diag_sel_ff)
         DIAG_INDEX: nxt_diag = (nxt_pos == POS_ZERO);
         DIAG_STEP: nxt_diag = nxt_toggle;
         default: nxt_diag = ctrl_en_ff && !nxt_bridge;
      endcase
   end

   // Protection registers.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= DRV_OFF;
         retry_ff <= '0;
         short_ff <= '0;
         otpw_ff <= 1'b0;
         ola_ff <= 1'b0;
         olb_ff <= 1'b0;
         bridge_ff <= 1'b0;
         diag_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         retry_ff <= nxt_retry;
         short_ff <= nxt_short;
         otpw_ff <= nxt_otpw;
         ola_ff <= nxt_ola;
         olb_ff <= nxt_olb;
         bridge_ff <= nxt_bridge;
         diag_ff <= nxt_diag;
      end
   end

   // ****************************************************************
   // APB registers and interrupts.
   // ****************************************************************
   // Events set sticky bits; a read of the status register clears them, but
   // an event in the same cycle survives the clear.
   always_comb begin
      events = '0;
      events[EV_HOT] = (nxt_state == DRV_HOT) && (state_ff != DRV_HOT);
      events[EV_OTPW] = temp_prewarn_in && !otpw_ff;
      events[EV_SHORT] = confirm;
      events[EV_OLA] = open_load_a_in && !ola_ff;
      events[EV_OLB] = open_load_b_in && !olb_ff;
      nxt_ctrl_en = ctrl_en_ff;
      nxt_diag_sel = diag_sel_ff;
      nxt_vel = vel_ff;
      nxt_thresh = thresh_ff;
      nxt_int_mask = int_mask_ff;
      nxt_int_stat = int_stat_ff;
      if (rd && paddr == OFF_INT_STATUS) nxt_int_stat = '0;
      nxt_int_stat = nxt_int_stat | events;
      nxt_pready = psel && !penable;
      nxt_pslverr = 1'b0;
      nxt_prdata = prdata_ff;
      if (psel && !penable) begin
         nxt_prdata = '0;
         case (paddr)
            OFF_CTRL: nxt_prdata[CTRL_SEL_HI:CTRL_EN] = {diag_sel_ff, ctrl_en_ff};
            OFF_VELOCITY: nxt_prdata = 32'(vel_ff);
            OFF_STATE: nxt_prdata = 32'({(ivl_ff <= thresh_ff), bridge_ff, olb_ff, ola_ff,
               short_ff, (state_ff == DRV_HOT), otpw_ff});
            OFF_POSITION: nxt_prdata = 32'(pos_ff);
            OFF_INTERVAL: nxt_prdata = 32'(ivl_ff);
            OFF_THRESHOLD: nxt_prdata = 32'(thresh_ff);
            OFF_INT_STATUS: nxt_prdata = 32'(int_stat_ff | events);
            OFF_INT_MASK: nxt_prdata = 32'(int_mask_ff);
            default: nxt_pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr)
            OFF_CTRL: begin
               nxt_ctrl_en = pwdata[CTRL_EN];
               nxt_diag_sel = pwdata[CTRL_SEL_HI:CTRL_SEL_LO];
            end
            OFF_VELOCITY: nxt_vel = pwdata[VEL_W-1:0];
            OFF_THRESHOLD: nxt_thresh = pwdata[IVL_W-1:0];
            OFF_INT_MASK: nxt_int_mask = pwdata[EV_W-1:0];
            default: nxt_ctrl_en = ctrl_en_ff;
         endcase
      end
      nxt_irq = |(nxt_int_stat & nxt_int_mask);
   end

   // Bus and interrupt registers.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_en_ff <= 1'b0;
         diag_sel_ff <= DIAG_ERROR;
         vel_ff <= '0;
         thresh_ff <= '0;
         int_stat_ff <= '0;
         int_mask_ff <= '0;
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         ctrl_en_ff <= nxt_ctrl_en;
         diag_sel_ff <= nxt_diag_sel;
         vel_ff <= nxt_vel;
         thresh_ff <= nxt_thresh;
         int_stat_ff <= nxt_int_stat;
         int_mask_ff <= nxt_int_mask;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         irq_ff <= nxt_irq;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign bridge_enable = bridge_ff;
   assign diag_pin = diag_ff;
   assign irq = irq_ff;

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_hot_drops_bridge: assert property ($rose(state_ff == DRV_HOT) |-> !bridge_ff)
      else $error("bridge on while overheated");
   a_hot_holds_off: assert property (state_ff == DRV_HOT && temp_prewarn_in |=> !bridge_ff)
      else $error("bridge back on above prewarning");
   a_short_retries: assert property ($rose(state_ff == DRV_SHORT)
      |-> $past(retry_ff) == SHORT_RETRIES)
      else $error("short confirmed before three retries");
   a_short_latches: assert property (state_ff == DRV_SHORT && ctrl_en_ff |=> !bridge_ff)
      else $error("bridge on after confirmed short");
   a_openload_inert: assert property (state_ff == DRV_ON && ctrl_en_ff && !temp_shutdown_in
      && !short_any && open_load_a_in |=> state_ff == DRV_ON)
      else $error("open load changed driver state");
   a_step_toggle: assert property (diag_sel_ff == DIAG_STEP && $stable(diag_sel_ff)
      && step_evt |=> diag_ff != $past(diag_ff))
      else $error("step mode pin missed a toggle");
   a_index_zero: assert property (diag_sel_ff == DIAG_INDEX && $stable(diag_sel_ff)
      |-> diag_ff == (pos_ff == POS_ZERO))
      else $error("index pin not at position zero");
   a_pos_advance: assert property (step_evt && !step_dir_down |=> pos_ff == $past(pos_ff) + STEP_W)
      else $error("position did not advance by step width");
   a_vel_zero_idle: assert property (vel_ff == '0 && !(ext_step_in && !ext_step_ff)
      |=> pos_ff == $past(pos_ff))
      else $error("position moved with zero velocity");
   a_diag_error: assert property (diag_sel_ff == DIAG_ERROR && $stable(diag_sel_ff)
      && $stable(ctrl_en_ff) |-> diag_ff == (ctrl_en_ff && !bridge_ff))
      else $error("error pin disagrees with driver state");
endmodule : stepgen_diag

// ### verif/front_end_model.sv
// Model of the analog front end that feeds the step and diagnostic block.
// Assumes the bench holds kind steady for the length of a short burst.
`timescale 1ns/10ps
module front_end_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset_n,
   // Commands from the bench.
   input wire logic [1:0] heat,
   input wire logic [1:0] ol,
   input wire logic [1:0] kind,
   input wire logic go,
   input wire logic [2:0] len,
   // Sensor lines.
   output logic [1:0] temp,
   output logic [3:0] short_ln,
   output logic [1:0] open_ln
);
   // ****************************************************************
   // Sensor behaviour.
   // ****************************************************************
   logic [2:0] left_ff;
   // A burst holds one short line high for len cycles, one detection each.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) left_ff <= 3'h0;
      else if (go) left_ff <= len;
      else if (left_ff != 3'h0) left_ff <= left_ff - 3'h1;
   end
   // Levels pass straight through, since temperature moves slowly anyway.
   assign temp = heat;
   assign open_ln = ol;
   assign short_ln = (left_ff != 3'h0) ? (4'h1 << kind) : 4'h0;
endmodule : front_end_model

// ### verif/stepgen_diag_tb.sv
// Self-checking bench for the step generator and diagnostics over APB.
// Assumes the front end model and USTEPS of 256, one step per 1/256 unit.
`timescale 1ns/10ps
module stepgen_diag_tb import stepgen_pkg::*;;
   // ****************************************************************
   // Signals and instances.
   // ****************************************************************
   logic clock, reset_n, psel, penable, pwrite, ext_step_in, ext_dir_in, go;
   logic pready, pslverr, bridge_enable, diag_pin, irq, err, dprev;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] heat, ol, kind, temp, open_ln;
   logic [2:0] len;
   logic [3:0] short_ln;
   logic [9:0] p0;
   int n_fail, n_compared, cnt;
   logic [7:0] ra [6] = '{OFF_CTRL, OFF_VELOCITY, OFF_POSITION, OFF_INTERVAL,
      OFF_THRESHOLD, OFF_INT_MASK};
   logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h000fffff, 32'h0, 32'h0};
   stepgen_diag #(.USTEPS(256)) dut_u (.clock(clock), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .temp_prewarn_in(temp[0]), .temp_shutdown_in(temp[1]),
      .short_gnd_a_in(short_ln[0]), .short_gnd_b_in(short_ln[1]),
      .short_vs_a_in(short_ln[2]), .short_vs_b_in(short_ln[3]),
      .open_load_a_in(open_ln[0]), .open_load_b_in(open_ln[1]),
      .ext_step_in(ext_step_in), .ext_dir_in(ext_dir_in),
      .bridge_enable(bridge_enable), .diag_pin(diag_pin), .irq(irq));
   front_end_model fe_u (.clock(clock), .reset_n(reset_n), .heat(heat), .ol(ol),
      .kind(kind), .go(go), .len(len), .temp(temp), .short_ln(short_ln),
      .open_ln(open_ln));
   // Free running 125 MHz clock.
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // ****************************************************************
   // Tasks.
   // ****************************************************************
   // Compare and count; unknowns never pass as a match.
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer; an idle edge follows so psel is never set twice at once.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) n_fail++;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb
   task cyc(input int k);
      repeat (k) @(posedge clock);
   endtask : cyc
   // Short burst of n detections on one line.
   task fire(input logic [1:0] k, input logic [2:0] n);
      kind <= k;
      len <= n;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      cyc(8);
   endtask : fire
   task complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   // Watchdog well past the thousand or so cycles the sequence needs.
   initial begin
      #(8 * 60000);
      n_fail++;
      complete_run();
   end
   // ****************************************************************
   // Test sequence.
   // ****************************************************************
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ext_step_in, ext_dir_in} = '0;
      {go, heat, ol, kind, len, reset_n} = '0;
      cyc(16);
      reset_n <= 1'b1;
      @(posedge clock);
      chk(bridge_enable, 1'b0);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, rv[i]);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, OFF_CTRL, 32'h1);
      cyc(3);
      chk(bridge_enable, 1'b1);
      // Fixed rate of one step every 16 clocks.
      apb(1'b1, OFF_THRESHOLD, 32'd20);
      apb(1'b1, OFF_VELOCITY, 32'h00100000);
      apb(1'b0, OFF_POSITION, 32'h0);
      p0 = rd[9:0];
      cyc(160);
      apb(1'b0, OFF_POSITION, 32'h0);
      p0 = rd[9:0] - p0;
      chk(p0 inside {10'd10, 10'd11}, 1'b1);
      apb(1'b0, OFF_INTERVAL, 32'h0);
      chk(rd, 32'h10);
      apb(1'b0, OFF_STATE, 32'h0);
      chk(rd[9:8], 2'b11);
      apb(1'b1, OFF_CTRL, 32'h5);
      cnt = 0;
      dprev = diag_pin;
      repeat (160) begin
         @(posedge clock);
         if (diag_pin !== dprev) cnt++;
         dprev = diag_pin;
      end
      chk(cnt inside {[9:11]}, 1'b1);
      // Count down through zero and wrap below it.
      apb(1'b1, OFF_VELOCITY, 32'h00f00000);
      apb(1'b1, OFF_CTRL, 32'h3);
      // Let the pin leave its step mode value before watching for the index.
      cyc(2);
      cnt = 0;
      while (diag_pin !== 1'b1 && cnt < 20000) begin
         @(posedge clock);
         cnt++;
      end
      apb(1'b0, OFF_POSITION, 32'h0);
      chk(rd, 32'h0);
      cyc(40);
      apb(1'b0, OFF_POSITION, 32'h0);
      chk(rd inside {[32'd1016:32'd1023]}, 1'b1);
      // Zero velocity leaves motion to the external step input.
      apb(1'b1, OFF_VELOCITY, 32'h0);
      apb(1'b0, OFF_POSITION, 32'h0);
      p0 = rd[9:0];
      repeat (3) begin
         ext_step_in <= 1'b1;
         cyc(2);
         ext_step_in <= 1'b0;
         cyc(2);
      end
      apb(1'b0, OFF_POSITION, 32'h0);
      chk(rd[9:0], 10'(p0 + 10'd3));
      // Open load while moving: flag and interrupt only.
      apb(1'b1, OFF_VELOCITY, 32'h00100000);
      apb(1'b1, OFF_CTRL, 32'h1);
      ol <= 2'b01;
      cyc(4);
      chk({irq, bridge_enable}, 2'b01);
      apb(1'b0, OFF_STATE, 32'h0);
      chk(rd[7:6], 2'b01);
      apb(1'b1, OFF_INT_MASK, 32'h08);
      cyc(2);
      chk(irq, 1'b1);
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      chk(rd[4:0], 5'h08);
      cyc(2);
      chk(irq, 1'b0);
      ol <= 2'b00;
      // Overheat, then cool to the warning band and below it.
      apb(1'b1, OFF_INT_MASK, 32'h1f);
      heat <= 2'b11;
      cyc(4);
      chk({irq, diag_pin, bridge_enable}, 3'b110);
      apb(1'b0, OFF_STATE, 32'h0);
      chk(rd[1:0], 2'b11);
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      chk(rd[4:0], 5'h03);
      heat <= 2'b01;
      cyc(20);
      chk(bridge_enable, 1'b0);
      heat <= 2'b00;
      cyc(4);
      chk(bridge_enable, 1'b1);
      // Each short type: three detections ride through, the fourth stops it.
      for (int k = 0; k < 4; k++) begin
         fire(2'(k), 3'd3);
         chk(bridge_enable, 1'b1);
         fire(2'(k), 3'd1);
         chk({diag_pin, bridge_enable}, 2'b10);
         apb(1'b0, OFF_STATE, 32'h0);
         chk(rd[2 + k], 1'b1);
         apb(1'b1, OFF_CTRL, 32'h1);
         cyc(3);
         chk(bridge_enable, 1'b0);
         apb(1'b1, OFF_CTRL, 32'h0);
         apb(1'b1, OFF_CTRL, 32'h1);
         cyc(3);
         chk(bridge_enable, 1'b1);
      end
      apb(1'b0, OFF_INT_STATUS, 32'h0);
      chk(rd[2], 1'b1);
      complete_run();
   end
endmodule : stepgen_diag_tb
